//--- shared/vsc_pkg.sv
// shared constants and types for the video serializer control block
package vsc_pkg;

  // dot clock multiplier of the on-chip oscillator
  localparam int unsigned DOT_MULT         = 5;
  // dots per video word and per character in windowed mode
  localparam int unsigned DOTS_PER_WORD    = 16;
  localparam int unsigned DOTS_PER_CHAR_W  = 8;
  localparam int unsigned WORD_W           = 16;
  localparam int unsigned CODE_W           = 3;
  localparam int unsigned FIFO_DEPTH       = 32;

  // dot counter positions
  localparam logic [3:0]  DOT_FIRST        = 4'h0;
  localparam logic [3:0]  DOT_LAST         = 4'hF;
  localparam logic [3:0]  DOT_MID          = 4'h7;
  localparam logic [2:0]  CHAR_LAST_W      = 3'h7;

  // extra shift pulse width after a transfer cycle
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned EXTRA_SHIFT_NS   = 200;
  localparam int unsigned EXTRA_SHIFT_CYC  =
    (EXTRA_SHIFT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  EXTRA_SHIFT_LD   = 2'(EXTRA_SHIFT_CYC);

  // reset values
  localparam logic        RST_BLANK        = 1'b1;
  localparam logic        RST_LOAD_N       = 1'b1;
  localparam logic [15:0] RST_WORD         = 16'h0000;
  localparam logic [2:0]  RST_CODE         = 3'h0;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [WORD_W-1:0] data;
  } vsc_entry_t;

endpackage

//--- logic/vsc_timer.sv
// dot counter producing character and video word clocks
module vsc_timer (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic windowed,
  output logic      character_clock,
  output logic      video_word_clock,
  output logic      char_last,
  output logic      word_last,
  output logic      word_mid
);

  logic [3:0] dot;
  logic [3:0] next_dot;

  assign next_dot  = 4'(dot + 4'h1);
  assign word_last = (dot == vsc_pkg::DOT_LAST);
  assign word_mid  = (dot == vsc_pkg::DOT_MID);
  assign char_last = windowed ? (dot[2:0] == vsc_pkg::CHAR_LAST_W) : word_last;

  // free running, never gated by blanking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dot <= vsc_pkg::DOT_FIRST;
    end else begin
      dot <= next_dot;
    end
  end

  // divide by sixteen, or by eight then two when windowed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      character_clock  <= 1'b1;
      video_word_clock <= 1'b1;
    end else begin
      character_clock  <= windowed ? !next_dot[2] : !next_dot[3];
      video_word_clock <= !next_dot[3];
    end
  end

endmodule // vsc_timer

//--- logic/vsc_fifo.sv
// word fifo with valid and ready on both sides
module vsc_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  assign rd_next    = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // head word registered; a word written into the next head slot passes through
  always_ff @(posedge clk) begin
    if (push && (wr_ptr == rd_next)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[rd_next];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
      rd_ptr    <= rd_next;
      count     <= next_count;
      in_ready  <= (next_count != (AW+1)'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end

endmodule // vsc_fifo

//--- logic/vsc_top.sv
// serializer load, shift clock and palette blanking control
// Functional notes
// - dot clock from 5x multiplier, video word clock is dot clock divided by 16
// - dot and word clocks run continuously, never gated by blanking
// - load pulse on last dot of any unblanked period where video control went low
// - first load after blanking ends loads word 0, then one load per word, or per character when windowed
// - plain mode: vram shift clock rises about eight dots after each load
// - serializer serial input is zero; loads suppressed outside active video
// - extra load after active video suppressed by resynchronised blanking
// - palette blank is controller blank ANDed with its delayed copy
// - one shift pulse after each transfer cycle, from the transfer strobe
// - plain mode, during active line, one vram shift edge per word clock
// - plain mode has no window; screen starts on a 16-bit boundary
// - windowed: character divider eight, word clock is character clock over two
// - windowed: first load of line produces first fifo shift-out pulse
// - start code from color data 0-2, input clock from data strobe, mux from video strobe
// - high and low bank serial clocks from data strobe, in opposite phase
// - all controller to fifo signals pass through this one block
// - controller blanking resynchronised to the word clock before it gates loads
module vsc_top #(
  parameter int unsigned WORD_W     = vsc_pkg::WORD_W,
  parameter int unsigned FIFO_DEPTH = vsc_pkg::FIFO_DEPTH
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      windowed_mode,
  input  wire logic                      video_control_in,
  input  wire logic                      controller_blank,
  input  wire logic                      transfer_strobe_n,
  input  wire logic                      data_strobe,
  input  wire logic                      video_strobe,
  input  wire logic [7:0]                color_data,
  input  wire logic [WORD_W-1:0]         vram_word,
  input  wire logic                      vram_valid,
  output logic                           vram_ready,
  output logic                           character_clock,
  output logic                           video_word_clock,
  output logic                           serializer_load_n,
  output logic [WORD_W-1:0]              serializer_word,
  output logic [vsc_pkg::CODE_W-1:0]     serializer_code,
  output logic                           serializer_serial_in,
  output logic                           vram_shift_clock,
  output logic                           resync_blank,
  output logic                           palette_blank,
  output logic                           fifo_shift_out_n,
  output logic                           fifo_input_clock,
  output logic [vsc_pkg::CODE_W-1:0]     start_position_code,
  output logic                           mux_select,
  output logic                           serial_clock_high_bank,
  output logic                           serial_clock_low_bank
);

  logic                char_last;
  logic                word_last;
  logic                word_mid;
  logic                vc_seen;
  logic                vc_low;
  logic                load_fire;
  logic                blank_dly;
  logic                line_active;
  logic                plain_shift;
  logic                next_plain_shift;
  logic [1:0]          extra_cnt;
  logic                transfer_strobe_n_q;
  logic                transfer_strobe_n_rise;
  logic                strobe_q;
  logic                strobe_rise;
  logic                bank_phase;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_pop;
  vsc_pkg::vsc_entry_t fifo_in;
  vsc_pkg::vsc_entry_t fifo_out;

  vsc_timer u_timer (
    .clk              (clk),
    .rst_n            (rst_n),
    .windowed         (windowed_mode),
    .character_clock  (character_clock),
    .video_word_clock (video_word_clock),
    .char_last        (char_last),
    .word_last        (word_last),
    .word_mid         (word_mid)
  );

  // video control seen low anywhere in the load period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vc_seen <= 1'b0;
    end else if (char_last) begin
      vc_seen <= 1'b0;
    end else if (!video_control_in) begin
      vc_seen <= 1'b1;
    end
  end

  assign vc_low    = vc_seen || !video_control_in;
  assign load_fire = char_last && vc_low && !resync_blank;
  assign fifo_pop  = load_fire && fifo_out_valid;

  // blanking resampled mid word, so the load at word end already sees it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resync_blank <= vsc_pkg::RST_BLANK;
      blank_dly    <= vsc_pkg::RST_BLANK;
    end else if (word_mid) begin
      resync_blank <= controller_blank;
      blank_dly    <= resync_blank;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      palette_blank <= vsc_pkg::RST_BLANK;
    end else begin
      palette_blank <= controller_blank && blank_dly;
    end
  end

  // active part of the line starts with the first load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_active <= 1'b0;
    end else if (load_fire) begin
      line_active <= 1'b1;
    end else if (resync_blank && word_last) begin
      line_active <= 1'b0;
    end
  end

  // load pulse and word handed to the final serializer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serializer_load_n <= vsc_pkg::RST_LOAD_N;
    end else begin
      serializer_load_n <= !load_fire;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serializer_word <= vsc_pkg::RST_WORD;
      serializer_code <= vsc_pkg::RST_CODE;
    end else if (load_fire) begin
      serializer_word <= fifo_out_valid ? fifo_out.data : '0;
      serializer_code <= fifo_out_valid ? fifo_out.code : '0;
    end else if (resync_blank) begin
      serializer_word <= '0;
      serializer_code <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serializer_serial_in <= 1'b0;
    end else begin
      serializer_serial_in <= 1'b0;
    end
  end

  // windowed mode: each load shifts the assembly fifo
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_shift_out_n <= 1'b1;
    end else begin
      fifo_shift_out_n <= !(load_fire && windowed_mode);
    end
  end

  // extra shift pulse after the trailing edge of a transfer strobe
  assign transfer_strobe_n_rise = transfer_strobe_n && !transfer_strobe_n_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transfer_strobe_n_q    <= 1'b1;
      extra_cnt <= 2'h0;
    end else begin
      transfer_strobe_n_q <= transfer_strobe_n;
      if (transfer_strobe_n_rise) begin
        extra_cnt <= vsc_pkg::EXTRA_SHIFT_LD;
      end else if (extra_cnt != 2'h0) begin
        extra_cnt <= 2'(extra_cnt - 2'h1);
      end
    end
  end

  // plain mode shift clock: rises mid word, falls at word end
  always_comb begin
    next_plain_shift = plain_shift;
    if (!line_active || windowed_mode) begin
      next_plain_shift = 1'b0;
    end else if (word_mid) begin
      next_plain_shift = 1'b1;
    end else if (word_last) begin
      next_plain_shift = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      plain_shift      <= 1'b0;
      vram_shift_clock <= 1'b0;
    end else begin
      plain_shift      <= next_plain_shift;
      vram_shift_clock <= (extra_cnt != 2'h0) || next_plain_shift;
    end
  end

  // fifo input clock, mux select and start code retimed in this one stage
  assign strobe_rise = data_strobe && !strobe_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_q            <= 1'b0;
      fifo_input_clock    <= 1'b0;
      mux_select          <= 1'b0;
      start_position_code <= vsc_pkg::RST_CODE;
    end else begin
      strobe_q            <= data_strobe;
      fifo_input_clock    <= data_strobe;
      mux_select          <= video_strobe;
      start_position_code <= windowed_mode ? color_data[2:0] : '0;
    end
  end

  // bank serial clocks toggle after each data strobe rise in windowed mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bank_phase             <= 1'b0;
      serial_clock_high_bank <= 1'b0;
      serial_clock_low_bank  <= 1'b1;
    end else begin
      if (strobe_rise && windowed_mode) begin
        bank_phase <= !bank_phase;
      end
      serial_clock_high_bank <= bank_phase;
      serial_clock_low_bank  <= !bank_phase;
    end
  end

  // word buffer between vram serial port and final serializer
  assign fifo_in_valid = windowed_mode ? strobe_rise : vram_valid;
  assign fifo_in.data  = vram_word;
  assign fifo_in.code  = windowed_mode ? color_data[2:0] : '0;

  vsc_fifo #(
    .WIDTH ($bits(vsc_pkg::vsc_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (fifo_in),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  assign vram_ready = fifo_in_ready;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_load_last_dot: assert property (
    !serializer_load_n |-> $past(char_last) && $past(vc_low))
    else $error("load pulse outside last dot or without video control low");

  a_load_blank_gate: assert property (
    !serializer_load_n |-> !$past(resync_blank))
    else $error("load pulse while blanking");

  a_shift_after_load: assert property (
    $fell(serializer_load_n) && !windowed_mode && !resync_blank
      ##1 !windowed_mode[*7] |-> ##1 vram_shift_clock)
    else $error("shift clock not high eight dots after load");

  a_zero_outside: assert property (
    $past(resync_blank) && serializer_load_n && !$past(load_fire)
      |-> serializer_word == '0 && !serializer_serial_in)
    else $error("serializer data not zero outside active video");

  a_palette_and: assert property (
    $past(rst_n) |-> palette_blank == ($past(controller_blank) && $past(blank_dly)))
    else $error("palette blank is not the and of blank and delayed blank");

  a_extra_shift: assert property (
    $rose(transfer_strobe_n) |-> ##2 vram_shift_clock[*2])
    else $error("no shift pulse after transfer cycle");

  a_code_follow: assert property (
    $past(windowed_mode) && $past(rst_n) |-> start_position_code == $past(color_data[2:0])
      && fifo_input_clock == $past(data_strobe))
    else $error("start code or fifo input clock not following controller");

  a_banks_opposite: assert property (
    serial_clock_high_bank != serial_clock_low_bank)
    else $error("bank serial clocks not in opposite phase");

  a_shift_out_load: assert property (
    !fifo_shift_out_n |-> !serializer_load_n && $past(windowed_mode))
    else $error("fifo shift out without load");

  a_resync_word: assert property (
    $changed(resync_blank) |-> $past(word_mid))
    else $error("blank resampled off the mid word point");

  a_load_in_line: assert property (
    !serializer_load_n |-> line_active)
    else $error("load pulse without active line");

  a_shift_each_word: assert property (
    line_active && !windowed_mode && word_last |-> vram_shift_clock)
    else $error("no shift clock edge in an active word");

  a_code_plain: assert property (
    !$past(windowed_mode) && $past(rst_n) |-> start_position_code == '0)
    else $error("start code not zero in plain mode");

  a_word_period: assert property (
    $rose(video_word_clock) |-> ##16 $rose(video_word_clock))
    else $error("word clock period not sixteen dots");

  c_plain_load: cover property (
    !windowed_mode && $fell(serializer_load_n));

  c_window_shift: cover property (
    windowed_mode && $fell(fifo_shift_out_n));

  c_transfer_shift: cover property (
    $rose(transfer_strobe_n) ##2 vram_shift_clock);

  c_fifo_full: cover property (!vram_ready);

  c_line_end: cover property (
    $rose(resync_blank) && line_active);

endmodule // vsc_top

//--- test/vsc_vram_model.sv
// vram serial port model feeding words into the block
module vsc_vram_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [5:0]  count,
  input  wire logic [15:0] base,
  input  wire logic        vram_ready,
  output logic [15:0]      vram_word,
  output logic             vram_valid,
  output logic [5:0]       left
);
  timeunit 1ns;
  timeprecision 1ns;

  // word held until taken; next word follows, inverse of the last word once all are taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left       <= 6'h00;
      vram_valid <= 1'b0;
      vram_word  <= 16'hFFFF;
    end else if (start) begin
      left       <= count;
      vram_valid <= (count != 6'h00);
      vram_word  <= base;
    end else if (vram_valid && vram_ready) begin
      left       <= left - 6'h01;
      vram_valid <= (left != 6'h01);
      vram_word  <= (left == 6'h01) ? ~vram_word : vram_word + 16'h0001;
    end
  end
endmodule // vsc_vram_model

//--- test/tb_video_serializer_control.sv
// self-checking bench for the serializer control block
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end

module tb_video_serializer_control;
  timeunit 1ns;
  timeprecision 1ns;

  int errors;
  int n_compared;
  logic clk, rst_n, windowed_mode, video_control_in, controller_blank;
  logic transfer_strobe_n, data_strobe, video_strobe, start;
  logic [7:0]  color_data;
  logic [5:0]  count;
  logic [15:0] base;
  logic [15:0] vram_word, serializer_word;
  logic [5:0]  left;
  logic [2:0]  serializer_code, start_position_code;
  logic vram_valid, vram_ready, character_clock, video_word_clock;
  logic serializer_load_n, serializer_serial_in, vram_shift_clock;
  logic resync_blank, palette_blank, fifo_shift_out_n, fifo_input_clock;
  logic mux_select, serial_clock_high_bank, serial_clock_low_bank;

  vsc_top dut (.clk, .rst_n, .windowed_mode, .video_control_in, .controller_blank,
    .transfer_strobe_n, .data_strobe, .video_strobe, .color_data, .vram_word,
    .vram_valid, .vram_ready, .character_clock, .video_word_clock, .serializer_load_n,
    .serializer_word, .serializer_code, .serializer_serial_in, .vram_shift_clock,
    .resync_blank, .palette_blank, .fifo_shift_out_n, .fifo_input_clock,
    .start_position_code, .mux_select, .serial_clock_high_bank, .serial_clock_low_bank);

  vsc_vram_model model (.clk, .rst_n, .start, .count, .base, .vram_ready, .vram_word,
    .vram_valid, .left);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tick(int n = 1);
    repeat (n) @(negedge clk);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_load(int lim);
    int i;
    i = 0;
    while (serializer_load_n !== 1'b0) begin
      tick();
      i++;
      if (i > lim) begin
        errors++;
        $display("wrong value load pulse exp 0 got 1");
        report_and_stop();
      end
    end
  endtask

  // distance between two rising edges of a clock output
  task automatic period(logic sel, int exp);
    logic p, c;
    int t0, t1, i;
    t0 = -1;
    t1 = -1;
    p = 1'b1;
    for (i = 0; i < 40; i++) begin
      c = sel ? video_word_clock : character_clock;
      if (c === 1'b1 && p === 1'b0) begin
        if (t0 < 0) t0 = i;
        else if (t1 < 0) t1 = i;
      end
      p = c;
      tick();
    end
    `CHK("clock period", exp, t1 - t0)
  endtask

  task automatic do_reset(logic win);
    rst_n = 1'b0;
    windowed_mode = win;
    tick(8);
    `CHK("reset load", 1'b1, serializer_load_n)
    `CHK("reset resync", 1'b1, resync_blank)
    `CHK("reset palette", 1'b1, palette_blank)
    `CHK("reset banks", 1'b1, serial_clock_low_bank & ~serial_clock_high_bank)
    `CHK("reset ready", 1'b1, vram_ready)
    rst_n = 1'b1;
  endtask

  task automatic test_transfer();
    int k;
    transfer_strobe_n = 1'b0;
    tick(3);
    `CHK("shift idle", 1'b0, vram_shift_clock)
    transfer_strobe_n = 1'b1;
    k = 0;
    repeat (8) begin
      tick();
      if (vram_shift_clock === 1'b1) k++;
    end
    `CHK("extra shift", int'(vsc_pkg::EXTRA_SHIFT_CYC), k)
    $display("transfer test done");
  endtask

  task automatic test_plain_line();
    int k;
    start = 1'b1;
    base = 16'hA000;
    count = 6'h24;
    tick();
    start = 1'b0;
    tick(45);
    `CHK("ready when full", 1'b0, vram_ready)
    `CHK("words held back", 6'h04, left)
    controller_blank = 1'b0;
    repeat (40) begin
      tick();
      `CHK("idle load", 1'b1, serializer_load_n)
    end
    video_control_in = 1'b0;
    tick();
    video_control_in = 1'b1;
    wait_load(20);
    `CHK("first word", 16'hA000, serializer_word)
    video_control_in = 1'b0;
    for (k = 1; k < 37; k++) begin
      `CHK("shift at load", 1'b0, vram_shift_clock)
      `CHK("plain shift out", 1'b1, fifo_shift_out_n)
      `CHK("plain code", 3'h0, start_position_code)
      tick(8);
      `CHK("shift mid word", 1'b1, vram_shift_clock)
      `CHK("palette active", 1'b0, palette_blank)
      `CHK("serial in", 1'b0, serializer_serial_in)
      tick(8);
      `CHK("load each word", 1'b0, serializer_load_n)
      `CHK("word", (k < 36) ? 16'hA000 + 16'(k) : 16'h0000, serializer_word)
    end
    controller_blank = 1'b1;
    k = 0;
    repeat (48) begin
      tick();
      if (serializer_load_n === 1'b0) k++;
    end
    `CHK("loads after line", 0, k)
    `CHK("word after line", 16'h0000, serializer_word)
    `CHK("palette blanking", 1'b1, palette_blank)
    video_control_in = 1'b1;
    $display("plain line test done");
  endtask

  task automatic test_windowed();
    int k;
    logic b;
    period(1'b0, 8);
    period(1'b1, 16);
    for (k = 0; k < 8; k++) begin
      b = serial_clock_high_bank;
      color_data = 8'hF8 | 8'(k);
      video_strobe = k[0];
      data_strobe = 1'b1;
      tick();
      `CHK("input clock", 1'b1, fifo_input_clock)
      `CHK("start code", 3'(k), start_position_code)
      `CHK("mux select", k[0], mux_select)
      data_strobe = 1'b0;
      tick(2);
      `CHK("high bank", ~b, serial_clock_high_bank)
      `CHK("low bank", b, serial_clock_low_bank)
    end
    controller_blank = 1'b0;
    video_control_in = 1'b0;
    wait_load(60);
    for (k = 0; k < 3; k++) begin
      `CHK("shift out", 1'b0, fifo_shift_out_n)
      `CHK("window code", 3'(k), serializer_code)
      tick(8);
      `CHK("char load", 1'b0, serializer_load_n)
    end
    controller_blank = 1'b1;
    video_control_in = 1'b1;
    $display("windowed test done");
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    video_control_in = 1'b1;
    controller_blank = 1'b1;
    transfer_strobe_n = 1'b1;
    data_strobe = 1'b0;
    video_strobe = 1'b0;
    color_data = 8'h00;
    start = 1'b0;
    count = 6'h00;
    base = 16'h0000;
    do_reset(1'b0);
    period(1'b0, 16);
    period(1'b1, 16);
    test_transfer();
    test_plain_line();
    do_reset(1'b1);
    test_windowed();
    report_and_stop();
  end
endmodule // tb_video_serializer_control
